// [bench/test_uart_host_select_latch.sv]
// Purpose: self-checking bench for the uart host select latch
// Assumes: host model drives pins, bench drives core-side inputs
// Notes: waits follow the two-flop pin latency plus one output edge
`timescale 1ns/1ps
module test_uart_host_select_latch;
  logic core_clk, rst, acc, tx_space, rx_avail, hi_a, hi_b, lo_n, as_n, bus, pc_n, osrc;
  logic [2:0] addr;
  logic [6:0] pc_addr;
  uhsl_pkg::uhsl_cond_t cond;
  uhsl_pkg::uhsl_sel_t sel_lat;
  logic chip_sel, pc_mode, int_pin, int_oe, tx_rdy_n, rx_rdy_n, int_wire;
  logic [3:0] com_hit;
  logic [1:0] lpt_n;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [6:0] PC_BASE [7] = '{uhsl_pkg::UHSL_COM1_BASE, uhsl_pkg::UHSL_COM2_BASE,
    uhsl_pkg::UHSL_COM3_BASE, uhsl_pkg::UHSL_COM4_BASE, uhsl_pkg::UHSL_LPT1_BASE,
    uhsl_pkg::UHSL_LPT2_BASE, 7'h00};
  localparam logic [5:0] PC_EXP [7] = '{6'h07, 6'h0B, 6'h13, 6'h23, 6'h02, 6'h01, 6'h03};

  ////////////////////////////////////////////////////////////////////////////
  // host model and design
  uhsl_host_model host_u (.chip_sel_hi_a_o(hi_a), .chip_sel_hi_b_o(hi_b), .chip_sel_lo_n_o(lo_n),
    .addr_o(addr), .addr_strobe_n_o(as_n), .bus_type_sel_o(bus), .pc_port_sel_n_o(pc_n),
    .int_open_src_o(osrc), .pc_addr_o(pc_addr));
  uhsl_top dut_u (.core_clk_i(core_clk), .rst_i(rst), .chip_sel_hi_a_i(hi_a), .chip_sel_hi_b_i(hi_b),
    .chip_sel_lo_n_i(lo_n), .addr_i(addr), .addr_strobe_n_i(as_n), .bus_type_sel_i(bus),
    .pc_port_sel_n_i(pc_n), .int_open_src_i(osrc), .pc_addr_i(pc_addr), .acc_active_i(acc),
    .cond_i(cond), .tx_space_i(tx_space), .rx_avail_i(rx_avail), .sel_lat_o(sel_lat),
    .chip_selected_o(chip_sel), .pc_mode_o(pc_mode), .com_hit_o(com_hit), .lpt_hit_n_o(lpt_n),
    .int_o(int_pin), .int_oe_o(int_oe), .tx_ready_n_o(tx_rdy_n), .rx_ready_n_o(rx_rdy_n));

  // interrupt wire: pull-up on open drain, pull-down on open source
  assign int_wire = int_oe ? int_pin : bus;

  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check({2'h0, sel_lat}, 8'h04);
    check({pc_mode, chip_sel, com_hit, lpt_n}, 8'h03);
    check({int_oe, tx_rdy_n, rx_rdy_n}, 8'h03);
  endtask

  // all select combinations, address moved after the strobe fall
  task automatic t_strobe_latch();
    uhsl_pkg::uhsl_sel_t s;
    host_u.set_mode(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      s = {3'(7 - i), i[2], i[1], i[0]};
      host_u.put_sel(s);
      step(4);
      host_u.strobe(1'b0);
      step(4);
      acc = 1'b1;
      host_u.put_sel(~s);
      step(4);
      check({2'h0, sel_lat}, {2'h0, s});
      check({7'h0, chip_sel}, {7'h0, i == 3});
      acc = 1'b0;
      host_u.strobe(1'b1);
      step(3);
      check({7'h0, chip_sel}, 8'h00);
    end
  endtask

  // strobe tied low: address taken at access start; ignored in line mode
  task automatic t_no_strobe();
    for (int b = 0; b < 2; b++) begin
      host_u.set_mode(b[0], 1'b1, 1'b0);
      step(4);
      host_u.strobe(1'b0);
      step(4);
      // a dummy access uses up the one fall that tying the strobe low makes
      acc = 1'b1;
      step(2);
      acc = 1'b0;
      host_u.put_sel(6'h2B);
      step(4);
      acc = 1'b1; // access marker; line-mode direction lives outside this block
      step(2);
      host_u.put_sel(6'h13);
      if (b == 1) host_u.strobe(1'b1);
      step(3);
      if (b == 1) host_u.strobe(1'b0);
      step(4);
      check({2'h0, sel_lat}, 8'h2B);
      check({7'h0, chip_sel}, 8'h01);
      acc = 1'b0;
      step(3);
    end
  endtask

  // each source in each interrupt style
  task automatic t_irq();
    for (int m = 0; m < 3; m++) begin
      host_u.set_mode(m == 2, 1'b1, m == 1);
      step(5);
      for (int k = 0; k < 5; k++) begin
        cond = (k < 4) ? 4'(1 << k) : 4'h0;
        step(3);
        // active level low only in line mode; push-pull always drives
        check({int_wire, int_oe}, {(k < 4) ^ (m == 2), (k < 4) || (m == 0)});
      end
    end
  endtask

  task automatic t_ready();
    for (int i = 0; i < 4; i++) begin
      tx_space = i[0];
      rx_avail = i[1];
      step(2);
      check({tx_rdy_n, rx_rdy_n}, {~i[0], ~i[1]});
    end
  endtask

  // port decode in pc mode, then both ways out of pc mode
  task automatic t_pc();
    host_u.set_mode(1'b0, 1'b0, 1'b0);
    for (int j = 0; j < 7; j++) begin
      host_u.put_pc(PC_BASE[j]);
      step(4);
      check({pc_mode, 1'b0, com_hit, lpt_n}, {2'h2, PC_EXP[j]});
    end
    for (int j = 0; j < 2; j++) begin
      host_u.put_pc(PC_BASE[j * 4]);
      host_u.set_mode(j == 0, j == 1, 1'b0);
      step(5);
      check({pc_mode, 1'b0, com_hit, lpt_n}, 8'h03);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    acc = 1'b0;
    cond = 4'h0;
    tx_space = 1'b0;
    rx_avail = 1'b0;
    step(3);
    t_reset();
    step(2);
    rst = 1'b0;
    step(4);
    t_strobe_latch();
    t_no_strobe();
    t_irq();
    t_ready();
    t_pc();
    conclude();
  end
endmodule

// [bench/uhsl_host_model.sv]
// Purpose: host processor model driving the select, address and mode pins
// Assumes: callers step just after a rising clock edge
// Notes: tasks only change pin levels; the caller owns all timing
`timescale 1ns/1ps
module uhsl_host_model (
  output logic chip_sel_hi_a_o,
  output logic chip_sel_hi_b_o,
  output logic chip_sel_lo_n_o,
  output logic [uhsl_pkg::UHSL_ADDR_W-1:0] addr_o,
  output logic addr_strobe_n_o,
  output logic bus_type_sel_o,
  output logic pc_port_sel_n_o,
  output logic int_open_src_o,
  output logic [uhsl_pkg::UHSL_PC_ADDR_W-1:0] pc_addr_o
);
  ////////////////////////////////////////////////////////////////////////////
  // idle levels: unused selects tied to their active level
  initial begin
    chip_sel_hi_a_o = 1'b1;
    chip_sel_hi_b_o = 1'b1;
    chip_sel_lo_n_o = 1'b0;
    addr_o = 3'h0;
    addr_strobe_n_o = 1'b1;
    bus_type_sel_o = 1'b0;
    pc_port_sel_n_o = 1'b1;
    int_open_src_o = 1'b0;
    pc_addr_o = 7'h00;
  end

  // system mode straps; a read/write-line host has no strobe and ties it low
  task automatic set_mode(input logic bus, input logic pc_n, input logic osrc);
    bus_type_sel_o = bus;
    pc_port_sel_n_o = pc_n;
    int_open_src_o = osrc;
    addr_strobe_n_o = ~bus;
  endtask

  // selects and address in latch layout
  task automatic put_sel(input uhsl_pkg::uhsl_sel_t sel);
    {addr_o, chip_sel_lo_n_o, chip_sel_hi_b_o, chip_sel_hi_a_o} = sel;
  endtask

  // address strobe level
  task automatic strobe(input logic v);
    addr_strobe_n_o = v;
  endtask

  // upper host address bits for the port decode
  task automatic put_pc(input logic [uhsl_pkg::UHSL_PC_ADDR_W-1:0] a);
    pc_addr_o = a;
  endtask
endmodule

// [logic/uhsl_int_drv.sv]
// Purpose: interrupt pin driver with mode-dependent polarity and style
// Assumes: request and mode inputs are on the core clock
// Notes: pin level and enable are registered; the wire is resolved outside
`timescale 1ns/1ps
module uhsl_int_drv (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic irq_req_i,
  input wire logic bus_type_i,
  input wire logic open_src_i,
  output logic int_o,
  output logic int_oe_o
);

  logic next_int;
  logic next_oe;

  // pick level and enable from bus mode and output style
  always_comb begin
    if (bus_type_i == uhsl_pkg::UHSL_BUS_RWLINE) begin
      next_int = 1'b0;                  // [RQ5]
      next_oe = irq_req_i;              // [RQ5] [RQ15]
    end else if (open_src_i) begin
      next_int = 1'b1;                  // [RQ4]
      next_oe = irq_req_i;              // [RQ4] [RQ15]
    end else begin
      next_int = irq_req_i;             // [RQ4]
      next_oe = 1'b1;
    end
  end

  // pin is released while in reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_o <= 1'b0;
      int_oe_o <= 1'b0;
    end else begin
      int_o <= next_int;
      int_oe_o <= next_oe;
    end
  end

endmodule

// [logic/uhsl_pkg.sv]
// Purpose: shared constants and types for the uart host select latch
// Assumes: one 100 MHz core clock, asynchronous active-high reset
// Notes: pin vector layout and the latch, ready and port-hit reset values are kept here only
package uhsl_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths and timing
  localparam int UHSL_ADDR_W = 3;
  localparam int UHSL_PC_ADDR_W = 7;
  localparam int UHSL_SYNC_STAGES = 2;
  localparam int UHSL_CLK_PERIOD_NS = 10;

  //////////////////////////////////////////////////////////////////////////////
  // bus mode, as set by the bus-type select pin
  typedef enum logic [0:0] {
    UHSL_BUS_STROBE = 1'b0,
    UHSL_BUS_RWLINE = 1'b1
  } uhsl_bus_t;

  //////////////////////////////////////////////////////////////////////////////
  // latched chip selects and low address lines
  typedef struct packed {
    logic [UHSL_ADDR_W-1:0] addr;
    logic chip_sel_lo_n;
    logic chip_sel_hi_b;
    logic chip_sel_hi_a;
  } uhsl_sel_t;

  // interrupt sources
  typedef struct packed {
    logic modem;
    logic line;
    logic rx;
    logic tx;
  } uhsl_cond_t;

  //////////////////////////////////////////////////////////////////////////////
  // synchronised pin vector layout
  localparam int UHSL_PIN_W = 17;
  localparam int UHSL_PIN_SEL_LSB = 0;
  localparam int UHSL_PIN_AS_N = 6;
  localparam int UHSL_PIN_BUS_TYPE = 7;
  localparam int UHSL_PIN_PC_SEL_N = 8;
  localparam int UHSL_PIN_OPEN_SRC = 9;
  localparam int UHSL_PIN_PC_ADDR_LSB = 10;
  // idle levels: active-low pins high, the rest low
  localparam logic [UHSL_PIN_W-1:0] UHSL_PIN_RST = 17'h00144;

  //////////////////////////////////////////////////////////////////////////////
  // reset values of registered outputs
  localparam uhsl_sel_t UHSL_SEL_RST = 6'h04;
  localparam logic UHSL_READY_N_RST = 1'b1;
  localparam logic [3:0] UHSL_COM_HIT_RST = 4'h0;
  localparam logic [1:0] UHSL_LPT_HIT_N_RST = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // port decode, address bits 9..3 of each port block
  localparam logic [UHSL_PC_ADDR_W-1:0] UHSL_COM1_BASE = 7'h7F;
  localparam logic [UHSL_PC_ADDR_W-1:0] UHSL_COM2_BASE = 7'h5F;
  localparam logic [UHSL_PC_ADDR_W-1:0] UHSL_COM3_BASE = 7'h7D;
  localparam logic [UHSL_PC_ADDR_W-1:0] UHSL_COM4_BASE = 7'h5D;
  localparam logic [UHSL_PC_ADDR_W-1:0] UHSL_LPT1_BASE = 7'h6F;
  localparam logic [UHSL_PC_ADDR_W-1:0] UHSL_LPT2_BASE = 7'h4F;

endpackage

// [logic/uhsl_sync.sv]
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: each bit is an independent level
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module uhsl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// [logic/uhsl_top.sv]
// Purpose: host-side chip select, address latch and status pins of a uart
// Assumes: pins are asynchronous; access and status inputs are on core_clk_i
// Notes: acc_active_i marks a read or write strobe from the strobe logic
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RQ1: access counts only with both high selects high and low select low.
// RQ2: host ties unused high selects high and unused low select low.
// RQ3: interrupt asserts while transmitter, receiver, line or modem condition is active.
// RQ4: strobe-bus mode interrupt is active high, optionally open-source.
// RQ5: read/write-line mode interrupt is active-low open-drain.
// RQ6: strobe-bus mode latches selects and address on address strobe fall.
// RQ7: address also latched at access start when address strobe unused.
// RQ8: address strobe ignored in read/write-line mode; may be tied low.
// RQ9: transmit-ready output is active low and follows transmit space.
// RQ10: receive-ready output is active low and follows receive data present.
// RQ11: pc mode needs pc port select and bus-type select both low.
// RQ12: pc mode decodes address lines 3..9 into serial and printer hits.
// RQ13: bus-type select low picks strobe bus, high picks read/write line.
// RQ14: host drives direction high to read, low to write.
// RQ15: open-drain or open-source interrupt line is released when idle.
module uhsl_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic chip_sel_hi_a_i,
  input wire logic chip_sel_hi_b_i,
  input wire logic chip_sel_lo_n_i,
  input wire logic [uhsl_pkg::UHSL_ADDR_W-1:0] addr_i,
  input wire logic addr_strobe_n_i,
  input wire logic bus_type_sel_i,
  input wire logic pc_port_sel_n_i,
  input wire logic int_open_src_i,
  input wire logic [uhsl_pkg::UHSL_PC_ADDR_W-1:0] pc_addr_i,
  input wire logic acc_active_i,
  input wire uhsl_pkg::uhsl_cond_t cond_i,
  input wire logic tx_space_i,
  input wire logic rx_avail_i,
  output uhsl_pkg::uhsl_sel_t sel_lat_o,
  output logic chip_selected_o,
  output logic pc_mode_o,
  output logic [3:0] com_hit_o,
  output logic [1:0] lpt_hit_n_o,
  output logic int_o,
  output logic int_oe_o,
  output logic tx_ready_n_o,
  output logic rx_ready_n_o
);

  logic [uhsl_pkg::UHSL_PIN_W-1:0] pin_raw;
  logic [uhsl_pkg::UHSL_PIN_W-1:0] pin_q;
  uhsl_pkg::uhsl_sel_t sel_live;
  uhsl_pkg::uhsl_sel_t next_sel_lat;
  logic as_n_q;
  logic as_n_d;
  logic as_fall;
  logic bus_type_q;
  logic pc_sel_n_q;
  logic open_src_q;
  logic [uhsl_pkg::UHSL_PC_ADDR_W-1:0] pc_addr_q;
  logic acc_d;
  logic acc_start;
  logic acc_end;
  logic as_cap;
  logic strobe_mode;
  logic irq_req;
  logic pc_mode;
  logic [uhsl_pkg::UHSL_PC_ADDR_W-1:0] com_base [4];
  logic [uhsl_pkg::UHSL_PC_ADDR_W-1:0] lpt_base [2];

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  assign pin_raw = {pc_addr_i, int_open_src_i, pc_port_sel_n_i, bus_type_sel_i, addr_strobe_n_i,
                    addr_i, chip_sel_lo_n_i, chip_sel_hi_b_i, chip_sel_hi_a_i};

  uhsl_sync #(
    .W(uhsl_pkg::UHSL_PIN_W),
    .RST_VAL(uhsl_pkg::UHSL_PIN_RST)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(pin_raw),
    .q_o(pin_q)
  );

  // unpack the synchronised pins
  assign sel_live = pin_q[uhsl_pkg::UHSL_PIN_SEL_LSB +: 6];
  assign as_n_q = pin_q[uhsl_pkg::UHSL_PIN_AS_N];
  assign bus_type_q = pin_q[uhsl_pkg::UHSL_PIN_BUS_TYPE];
  assign pc_sel_n_q = pin_q[uhsl_pkg::UHSL_PIN_PC_SEL_N];
  assign open_src_q = pin_q[uhsl_pkg::UHSL_PIN_OPEN_SRC];
  assign pc_addr_q = pin_q[uhsl_pkg::UHSL_PIN_PC_ADDR_LSB +: uhsl_pkg::UHSL_PC_ADDR_W];

  //////////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised strobe and on the access marker
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      as_n_d <= 1'b1;
      acc_d <= 1'b0;
    end else begin
      as_n_d <= as_n_q;
      acc_d <= acc_active_i;
    end
  end

  assign strobe_mode = (bus_type_q == uhsl_pkg::UHSL_BUS_STROBE);   // [RQ13]
  assign as_fall = strobe_mode && as_n_d && !as_n_q;                // [RQ6] [RQ8]
  assign acc_start = acc_active_i && !acc_d;
  assign acc_end = !acc_active_i && acc_d;

  // remembers that the strobe already captured this access
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      as_cap <= 1'b0;
    end else if (as_fall) begin
      as_cap <= 1'b1;                                               // [RQ6]
    end else if (acc_end || !strobe_mode) begin
      as_cap <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // select and address latch
  always_comb begin
    next_sel_lat = sel_lat_o;
    if (as_fall) begin
      next_sel_lat = sel_live;                                      // [RQ6]
    end else if (acc_start && !as_cap) begin
      next_sel_lat = sel_live;                                      // [RQ7] [RQ8]
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_lat_o <= uhsl_pkg::UHSL_SEL_RST;
    end else begin
      sel_lat_o <= next_sel_lat;
    end
  end

  // all three selects must be active together
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chip_selected_o <= 1'b0;
    end else begin
      chip_selected_o <= acc_active_i && next_sel_lat.chip_sel_hi_a
                         && next_sel_lat.chip_sel_hi_b && !next_sel_lat.chip_sel_lo_n;   // [RQ1]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pc mode port decode
  assign pc_mode = !pc_sel_n_q && strobe_mode;                      // [RQ11]
  assign com_base[0] = uhsl_pkg::UHSL_COM1_BASE;
  assign com_base[1] = uhsl_pkg::UHSL_COM2_BASE;
  assign com_base[2] = uhsl_pkg::UHSL_COM3_BASE;
  assign com_base[3] = uhsl_pkg::UHSL_COM4_BASE;
  assign lpt_base[0] = uhsl_pkg::UHSL_LPT1_BASE;
  assign lpt_base[1] = uhsl_pkg::UHSL_LPT2_BASE;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_mode_o <= 1'b0;
    end else begin
      pc_mode_o <= pc_mode;
    end
  end

  // one comparator per serial port
  for (genvar i = 0; i < 4; i++) begin : g_com
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        com_hit_o[i] <= uhsl_pkg::UHSL_COM_HIT_RST[i];
      end else begin
        com_hit_o[i] <= pc_mode && (pc_addr_q == com_base[i]);    // [RQ12]
      end
    end
  end

  // one comparator per printer port, active low
  for (genvar j = 0; j < 2; j++) begin : g_lpt
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        lpt_hit_n_o[j] <= uhsl_pkg::UHSL_LPT_HIT_N_RST[j];
      end else begin
        lpt_hit_n_o[j] <= !(pc_mode && (pc_addr_q == lpt_base[j]));   // [RQ12]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt request and pin driver
  assign irq_req = |cond_i;                                         // [RQ3]

  uhsl_int_drv u_int_drv (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .irq_req_i(irq_req),
    .bus_type_i(bus_type_q),
    .open_src_i(open_src_q),
    .int_o(int_o),
    .int_oe_o(int_oe_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // ready status pins, active low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_n_o <= uhsl_pkg::UHSL_READY_N_RST;
      rx_ready_n_o <= uhsl_pkg::UHSL_READY_N_RST;
    end else begin
      tx_ready_n_o <= !tx_space_i;                                  // [RQ9]
      rx_ready_n_o <= !rx_avail_i;                                  // [RQ10]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_as_fall_strobe;
    strobe_mode && as_fall;
  endsequence

  sequence s_start_no_strobe;
    acc_start && !as_fall && !as_cap;
  endsequence

  sequence s_held_access;
    acc_active_i && acc_d && !as_fall && !acc_start;
  endsequence

  sel_qualify_a: assert property (                                  // [RQ1]
    chip_selected_o == ($past(acc_active_i) && sel_lat_o.chip_sel_hi_a
                        && sel_lat_o.chip_sel_hi_b && !sel_lat_o.chip_sel_lo_n))
    else $error("chip selected without all selects active");

  irq_any_a: assert property (                                      // [RQ3]
    (irq_req ##1 irq_req) |-> int_oe_o && (int_o != $past(bus_type_q)))
    else $error("interrupt pin not driven for active condition");

  strobe_int_a: assert property (                                   // [RQ4]
    (strobe_mode && irq_req) |=> (int_o && int_oe_o))
    else $error("strobe mode interrupt not active high");

  rwline_int_a: assert property (                                   // [RQ5]
    (!strobe_mode && irq_req) |=> (!int_o && int_oe_o))
    else $error("read/write mode interrupt not driven low");

  as_latch_a: assert property (                                     // [RQ6]
    s_as_fall_strobe |=> (sel_lat_o == $past(sel_live)))
    else $error("strobe did not capture selects and address");

  start_latch_a: assert property (                                  // [RQ7]
    s_start_no_strobe |=> sel_lat_o == $past(sel_live))
    else $error("address not captured at access start");

  rw_ignore_as_a: assert property (                                 // [RQ8]
    (!strobe_mode && !acc_start && as_n_d && !as_n_q) |=> $stable(sel_lat_o))
    else $error("address strobe acted in read/write mode");

  hold_access_a: assert property (                                  // [RQ6]
    s_held_access |=> $stable(sel_lat_o))
    else $error("latched address changed during access");

  tx_ready_a: assert property (                                     // [RQ9]
    (tx_space_i ##1 tx_space_i) |-> !tx_ready_n_o ##1 !tx_ready_n_o)
    else $error("transmit ready does not follow space");

  rx_ready_a: assert property (                                     // [RQ10]
    (!rx_avail_i ##1 !rx_avail_i) |-> rx_ready_n_o)
    else $error("receive ready asserted without data");

  pc_decode_a: assert property (                                    // [RQ12]
    !pc_mode |=> (com_hit_o == 4'h0) && (lpt_hit_n_o == 2'h3) && !pc_mode_o)
    else $error("port decode active outside pc mode");

  int_release_a: assert property (                                  // [RQ15]
    ((!strobe_mode || open_src_q) && !irq_req) |=> !int_oe_o)
    else $error("shared interrupt line not released when idle");

  com1_hit_a: assert property (                                     // [RQ12]
    (pc_mode && (pc_addr_q == uhsl_pkg::UHSL_COM1_BASE)) |=> (com_hit_o == 4'h1) && (lpt_hit_n_o == 2'h3))
    else $error("first serial port address not decoded");

  idle_unsel_a: assert property (                                   // [RQ1]
    !acc_active_i |=> !chip_selected_o)
    else $error("chip selected outside an access");

  pushpull_idle_a: assert property (                                // [RQ4]
    (strobe_mode && !open_src_q && !irq_req) |=> (!int_o && int_oe_o))
    else $error("push-pull interrupt not driven inactive");

  cap_clear_a: assert property (                                    // [RQ7]
    (acc_end && !as_fall) |=> !as_cap)
    else $error("strobe capture flag kept past the access");

  pc_mode_out_a: assert property (                                  // [RQ11]
    pc_mode |=> pc_mode_o)
    else $error("pc mode not reported");

  tx_busy_a: assert property (                                      // [RQ9]
    !tx_space_i |=> tx_ready_n_o)
    else $error("transmit ready asserted without space");

  rx_data_a: assert property (                                      // [RQ10]
    rx_avail_i |=> !rx_ready_n_o)
    else $error("receive ready not asserted with data");

endmodule
